// [verilog/sradr_pkg.sv]
// Purpose: shared constants and types for region operand addressing
// Assumes: one unit clock, decode logic drives whole instructions
// Notes: byte addresses span 128 registers of 32 bytes
package sradr_pkg;
  // ************************************************
  // Widths and field positions
  // ************************************************
  localparam int ADDR_W = 12;
  localparam int REG_SHIFT = 5;
  localparam logic [3:0] ALIGN_MASK = 4'hf;
  localparam int VEC_INT_W = 4;
  localparam int VEC_FLT_W = 8;
  localparam int HALF_W = 16;
  // ************************************************
  // Register map and bit positions
  // ************************************************
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_CNT = 4'h8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int CTRL_EN = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_SPAN = 1;
  localparam int ST_ERR = 4;
  // Element types, one per operand
  typedef enum logic [3:0] {
    TY_UD = 4'h0, TY_D = 4'h1, TY_UW = 4'h2, TY_W = 4'h3,
    TY_UB = 4'h4, TY_B = 4'h5, TY_F = 4'h6, TY_V = 4'h7,
    TY_UV = 4'h8, TY_VF = 4'h9
  } sradr_type_t;
  // Region description of one operand
  typedef struct packed {
    logic [6:0] register_index;
    logic [4:0] subregister_offset;
    logic [5:0] vertical_step;
    logic [2:0] width_log;
    logic [2:0] horizontal_step;
    sradr_type_t ty;
  } sradr_opnd_t;
  // Whole instruction from decode
  typedef struct packed {
    logic [2:0] channel_count_log;
    logic reduce;
    logic src1_imm;
    sradr_opnd_t src0;
    sradr_opnd_t src1;
    sradr_opnd_t dst;
    logic [31:0] imm;
  } sradr_instr_t;
  // One channel's addresses toward the register array
  typedef struct packed {
    logic [4:0] idx;
    logic [ADDR_W-1:0] src0_addr;
    logic [ADDR_W-1:0] src1_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic dst_we;
    logic [31:0] imm_elem;
  } sradr_chan_t;
endpackage

// [verilog/sradr_core.sv]
// Purpose: per-channel byte addresses from region descriptions
// Assumes: decode shares clk_sys_i, holds nothing after acceptance
// Notes: one channel per cycle; an erroneous instruction is dropped
`timescale 1ns/1ps
// Functional notes
// RL1 - Word immediates replicated in both halves
// RL2 - Byte immediate types are rejected
// RL3 - Integer vector immediate: eight 4-bit elements
// RL4 - Float vector immediate: four 8-bit elements
// RL5 - Vector immediate needs aligned, fixed-step destination
// RL6 - Both sources hold equal element counts
// RL7 - Reduction destination smaller than source
// RL8 - Register in 256 bits, offset in elements
// RL9 - Offset low five bits, register above
// RL10 - Rows equal channel count over width
// RL11 - Elements one horizontal step apart
// RL12 - Rows one vertical step apart, may interleave
// RL13 - One element type per operand
// RL14 - Origin is register shifted plus offset
// RL15 - Channels assigned row-major
// RL16 - Destination one-dimensional, horizontal step only
// RL17 - Destination stays in one register
// RL18 - Sources may span several registers
// RL19 - Channel count from instruction sizes regions
module sradr_core (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic issue_valid_i,
  input wire sradr_pkg::sradr_instr_t issue_i,
  output logic ready_o,
  output logic chan_valid_o,
  output sradr_pkg::sradr_chan_t chan_o,
  output logic done_o,
  output logic err_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);
  localparam int AW = sradr_pkg::ADDR_W;
  typedef enum logic [1:0] {S_IDLE = 2'b01, S_WALK = 2'b10} sradr_state_t;

  // ************************************************
  // Helper functions
  // ************************************************
  // Element size in bytes
  function automatic logic [AW-1:0] esize(input sradr_pkg::sradr_type_t ty);
    unique case (ty)
      sradr_pkg::TY_UB, sradr_pkg::TY_B: esize = AW'(1); // see RL14
      sradr_pkg::TY_UW, sradr_pkg::TY_W, sradr_pkg::TY_V, sradr_pkg::TY_UV: esize = AW'(2);
      default: esize = AW'(4);
    endcase
  endfunction

  // Byte address of a region origin
  function automatic logic [AW-1:0] origin(input sradr_pkg::sradr_opnd_t op);
    origin = (AW'(op.register_index) << sradr_pkg::REG_SHIFT) // see RL8 see RL9
      + AW'(op.subregister_offset) * esize(op.ty); // see RL14
  endfunction

  // Step in bytes
  function automatic logic [AW-1:0] sbytes(input logic [5:0] st, input sradr_pkg::sradr_type_t ty);
    sbytes = AW'(st) * esize(ty);
  endfunction

  function automatic logic is_byte(input sradr_pkg::sradr_type_t ty);
    is_byte = (ty == sradr_pkg::TY_UB) || (ty == sradr_pkg::TY_B);
  endfunction

  // Immediate element handed to a channel
  function automatic logic [31:0] imm_elem(input sradr_pkg::sradr_type_t ty,
                                           input logic [31:0] imm, input logic [4:0] ch);
    logic [3:0] nib;
    logic [7:0] byt;
    nib = imm[ch[2:0]*sradr_pkg::VEC_INT_W +: sradr_pkg::VEC_INT_W];
    byt = imm[ch[1:0]*sradr_pkg::VEC_FLT_W +: sradr_pkg::VEC_FLT_W];
    unique case (ty)
      sradr_pkg::TY_V: imm_elem = 32'(signed'(nib)); // see RL3
      sradr_pkg::TY_UV: imm_elem = 32'(nib); // see RL3
      sradr_pkg::TY_VF: imm_elem = 32'(byt); // see RL4
      // Low half only: the high copy is assumed identical
      sradr_pkg::TY_W: imm_elem = 32'(signed'(imm[sradr_pkg::HALF_W-1:0])); // see RL1
      sradr_pkg::TY_UW: imm_elem = 32'(imm[sradr_pkg::HALF_W-1:0]); // see RL1
      default: imm_elem = imm;
    endcase
  endfunction

  // ************************************************
  // Issue checks
  // ************************************************
  sradr_state_t state_q;
  sradr_pkg::sradr_instr_t cur_q;
  logic ready_q, err_q, done_q, chan_valid_q, span_q;
  sradr_pkg::sradr_chan_t chan_q;
  logic [31:0] ctrl_q, rdata_q;
  logic [15:0] cnt_q;
  logic [3:0] errs_q;
  logic [4:0] ch_q;
  logic [4:0] x_q [2];
  logic [AW-1:0] off_q [2];
  logic [AW-1:0] rbase_q [2];
  logic [AW-1:0] dst_q;
  logic [6:0] oreg_q [2];
  logic [6:0] dreg_q;

  logic e_byte, e_vec, e_width, e_span, is_vec, acc, acc_ok;
  logic [AW-1:0] d_org, first0, first1;
  logic [AW:0] d_last;
  logic [5:0] n_dst;
  // Error vector checked against the raw issue fields
  always_comb begin
    is_vec = issue_i.src1_imm && (issue_i.src1.ty inside
             {sradr_pkg::TY_V, sradr_pkg::TY_UV, sradr_pkg::TY_VF});
    e_byte = issue_i.src1_imm && is_byte(issue_i.src1.ty); // see RL2
    d_org = origin(issue_i.dst);
    // Reduction writes one result per channel pair
    n_dst = issue_i.reduce ? 6'(6'h1 << issue_i.channel_count_log) >> 1 // see RL7
                           : 6'(6'h1 << issue_i.channel_count_log); // see RL19
    d_last = (AW+1)'(d_org) + (AW+1)'((AW'(n_dst) - AW'(1))
             * sbytes(6'(issue_i.dst.horizontal_step), issue_i.dst.ty))
             + (AW+1)'(esize(issue_i.dst.ty)) - (AW+1)'(1);
    // A destination leaving its register is dropped, not split
    e_span = d_last[AW:sradr_pkg::REG_SHIFT] != (AW+1-sradr_pkg::REG_SHIFT)'(
             d_org[AW-1:sradr_pkg::REG_SHIFT]);
    e_vec = is_vec && (((d_org[3:0] & sradr_pkg::ALIGN_MASK) != 4'h0)
            || (sbytes(6'(issue_i.dst.horizontal_step), issue_i.dst.ty)
                != ((issue_i.src1.ty == sradr_pkg::TY_VF) ? AW'(4) : AW'(2))));
    // Width may not exceed the channel count
    e_width = (issue_i.src0.width_log > issue_i.channel_count_log)
      || (!issue_i.src1_imm && issue_i.src1.width_log > issue_i.channel_count_log); // see RL10
    first0 = origin(issue_i.src0);
    // Held in a variable: a function result cannot be part-selected
    first1 = origin(issue_i.src1);
    acc = issue_valid_i && ready_q;
    acc_ok = acc && !(e_byte || e_vec || e_width || e_span);
  end

  // ************************************************
  // Channel walk
  // ************************************************
  logic last_ch;
  assign last_ch = (ch_q == 5'((6'h1 << cur_q.channel_count_log) - 6'h1));

  // Sequencer, ready and completion pulses
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_q <= S_IDLE;
      ready_q <= 1'b0;
      err_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      err_q <= acc && !acc_ok;
      done_q <= (state_q == S_WALK) && last_ch;
      unique case (state_q)
        S_IDLE: begin
          if (acc_ok) begin
            state_q <= S_WALK;
            ready_q <= 1'b0;
          end else begin
            ready_q <= ctrl_q[sradr_pkg::CTRL_EN];
          end
        end
        S_WALK: begin
          if (last_ch) begin
            state_q <= S_IDLE;
            ready_q <= ctrl_q[sradr_pkg::CTRL_EN];
          end
        end
        default: begin
          state_q <= S_IDLE;
          ready_q <= 1'b0;
        end
      endcase
    end
  end

  // Address generators, both sources share one channel counter
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cur_q <= '0;
      ch_q <= 5'h0;
      dst_q <= '0;
      dreg_q <= 7'h0;
      for (int s = 0; s < 2; s++) begin
        x_q[s] <= 5'h0;
        off_q[s] <= '0;
        rbase_q[s] <= '0;
        oreg_q[s] <= 7'h0;
      end
    end else if (state_q == S_IDLE) begin
      if (acc_ok) begin
        cur_q <= issue_i;
        ch_q <= 5'h0;
        dst_q <= d_org;
        dreg_q <= d_org[AW-1:sradr_pkg::REG_SHIFT];
        for (int s = 0; s < 2; s++) begin
          x_q[s] <= 5'h0;
          off_q[s] <= (s == 0) ? first0 : first1; // see RL14
          rbase_q[s] <= (s == 0) ? first0 : first1;
          oreg_q[s] <= (s == 0) ? first0[AW-1:sradr_pkg::REG_SHIFT]
                                : first1[AW-1:sradr_pkg::REG_SHIFT];
        end
      end
    end else begin
      ch_q <= ch_q + 5'h1;
      // Destination is linear; reduction advances on odd channels
      if (!cur_q.reduce || ch_q[0]) begin
        dst_q <= dst_q + sbytes(6'(cur_q.dst.horizontal_step), cur_q.dst.ty); // see RL16
      end
      for (int s = 0; s < 2; s++) begin
        if (x_q[s] == 5'((6'h1 << (s == 0 ? cur_q.src0.width_log
                                          : cur_q.src1.width_log)) - 6'h1)) begin
          // Row done: next row one vertical step on, may interleave
          x_q[s] <= 5'h0; // see RL15
          rbase_q[s] <= rbase_q[s] + ((s == 0) ? sbytes(cur_q.src0.vertical_step, cur_q.src0.ty)
                        : sbytes(cur_q.src1.vertical_step, cur_q.src1.ty)); // see RL12
          off_q[s] <= rbase_q[s] + ((s == 0) ? sbytes(cur_q.src0.vertical_step, cur_q.src0.ty)
                      : sbytes(cur_q.src1.vertical_step, cur_q.src1.ty));
        end else begin
          x_q[s] <= x_q[s] + 5'h1;
          off_q[s] <= off_q[s] + ((s == 0)
            ? sbytes(6'(cur_q.src0.horizontal_step), cur_q.src0.ty)
            : sbytes(6'(cur_q.src1.horizontal_step), cur_q.src1.ty)); // see RL11
        end
      end
    end
  end

  // Channel output, one element per cycle toward the array
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      chan_valid_q <= 1'b0;
      chan_q <= '0;
    end else begin
      chan_valid_q <= (state_q == S_WALK);
      if (state_q == S_WALK) begin
        chan_q.idx <= ch_q;
        chan_q.src0_addr <= off_q[0];
        chan_q.src1_addr <= cur_q.src1_imm ? '0 : off_q[1];
        chan_q.dst_addr <= dst_q;
        chan_q.dst_we <= !cur_q.reduce || !ch_q[0]; // see RL7
        chan_q.imm_elem <= cur_q.src1_imm ? imm_elem(cur_q.src1.ty, cur_q.imm, ch_q) : 32'h0;
      end
    end
  end

  // Multi-register gather seen; decode may budget extra cycles
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      span_q <= 1'b0;
    end else if (acc_ok) begin
      span_q <= 1'b0;
    end else if (state_q == S_WALK) begin
      if (off_q[0][AW-1:sradr_pkg::REG_SHIFT] != oreg_q[0]
          || (!cur_q.src1_imm && off_q[1][AW-1:sradr_pkg::REG_SHIFT] != oreg_q[1])) begin
        span_q <= 1'b1; // see RL18
      end
    end
  end

  // ************************************************
  // Software registers
  // ************************************************
  // Control, last error vector, completion count
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl_q <= sradr_pkg::CTRL_RST;
      errs_q <= 4'h0;
      cnt_q <= 16'h0;
      rdata_q <= 32'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == sradr_pkg::OFF_CTRL) begin
        ctrl_q <= reg_wdata_i;
      end
      if (acc) begin
        errs_q <= {e_span, e_width, e_vec, e_byte};
      end
      // Completion wins over a clearing write
      if (done_q) begin
        cnt_q <= cnt_q + 16'h1;
      end else if (reg_wr_i && reg_addr_i == sradr_pkg::OFF_CNT) begin
        cnt_q <= 16'h0;
      end
      rdata_q <= 32'h0;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          sradr_pkg::OFF_CTRL: rdata_q <= ctrl_q;
          sradr_pkg::OFF_STAT: rdata_q <= 32'({errs_q, 2'h0, span_q, state_q == S_WALK});
          sradr_pkg::OFF_CNT: rdata_q <= 32'(cnt_q);
          default: rdata_q <= 32'h0;
        endcase
      end
    end
  end

  assign ready_o = ready_q;
  assign chan_valid_o = chan_valid_q;
  assign chan_o = chan_q;
  assign done_o = done_q;
  assign err_o = err_q;
  assign reg_rdata_o = rdata_q;

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  logic [5:0] emit_q;
  // Channels emitted before the current beat of this instruction
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || done_q) begin
      emit_q <= 6'h0;
    end else if (chan_valid_q) begin
      emit_q <= emit_q + 6'h1;
    end
  end

  a_first_addr: assert property (acc_ok |-> ##2 (chan_valid_q && chan_q.idx == 5'h0 && // see RL14
    chan_q.src0_addr == $past(first0, 2))) else $error("origin address wrong");
  a_byte_imm_rej: assert property (acc && e_byte |=> err_q && state_q == S_IDLE) // see RL2
    else $error("byte immediate accepted");
  a_row_step: assert property ((state_q == S_WALK) && !last_ch && // see RL11
    x_q[0] != 5'((6'h1 << cur_q.src0.width_log) - 6'h1) |=>
    off_q[0] == $past(off_q[0]) + sbytes(6'(cur_q.src0.horizontal_step), cur_q.src0.ty))
    else $error("in-row step wrong");
  a_row_next: assert property ((state_q == S_WALK) && !last_ch && // see RL12
    x_q[0] == 5'((6'h1 << cur_q.src0.width_log) - 6'h1) |=>
    off_q[0] == $past(rbase_q[0]) + sbytes(cur_q.src0.vertical_step, cur_q.src0.ty)
    && x_q[0] == 5'h0) else $error("row advance wrong");
  // Last beat shares its cycle with done, so it is not yet counted
  a_chan_total: assert property (done_q |-> // see RL19
    emit_q + 6'h1 == 6'(6'h1 << cur_q.channel_count_log)) else $error("channel total wrong");
  a_dst_one_reg: assert property (chan_valid_q && chan_q.dst_we |-> // see RL17
    chan_q.dst_addr[AW-1:sradr_pkg::REG_SHIFT] == dreg_q) else $error("destination left reg");
  a_vec_int_elem: assert property (chan_valid_q && cur_q.src1_imm && // see RL3
    cur_q.src1.ty == sradr_pkg::TY_UV |-> chan_q.imm_elem ==
    32'(cur_q.imm[chan_q.idx[2:0]*sradr_pkg::VEC_INT_W +: sradr_pkg::VEC_INT_W]))
    else $error("int vector element wrong");
  a_vec_flt_elem: assert property (chan_valid_q && cur_q.src1_imm && // see RL4
    cur_q.src1.ty == sradr_pkg::TY_VF |-> chan_q.imm_elem ==
    32'(cur_q.imm[chan_q.idx[1:0]*sradr_pkg::VEC_FLT_W +: sradr_pkg::VEC_FLT_W]))
    else $error("float vector element wrong");
  a_reduce_dst: assert property (chan_valid_q && cur_q.reduce |-> // see RL7
    chan_q.dst_we == !chan_q.idx[0]) else $error("reduction write wrong");

  c_accept: cover property (acc_ok ##1 (state_q == S_WALK) [*4]);
  c_reject: cover property (acc && e_vec ##1 err_q);
  c_reduce: cover property (chan_valid_q && cur_q.reduce && done_q);
  c_span: cover property (chan_valid_q && span_q);
endmodule

// [bench/sradr_decode_model.sv]
// Purpose: decode side model that offers instructions to the core
// Assumes: one request at a time, held until the core takes it
// Notes: a released issue bus shows the inverse of its last value
`timescale 1ns/1ps
module sradr_decode_model (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic req_i,
  input wire sradr_pkg::sradr_instr_t instr_i,
  input wire logic ready_i,
  output logic issue_valid_o,
  output sradr_pkg::sradr_instr_t issue_o,
  output logic taken_o
);
  sradr_pkg::sradr_instr_t hold_q;
  sradr_pkg::sradr_instr_t fix_d;

  // Word immediates go out with both halves equal
  always_comb begin
    fix_d = instr_i;
    if (instr_i.src1_imm && (instr_i.src1.ty == sradr_pkg::TY_W ||
        instr_i.src1.ty == sradr_pkg::TY_UW)) begin
      fix_d.imm = {instr_i.imm[15:0], instr_i.imm[15:0]};
    end
  end

  // Offer held until taken; one type per operand by construction
  always_ff @(posedge clk_sys_i) begin
    taken_o <= 1'b0;
    if (srst_i) begin
      issue_valid_o <= 1'b0;
      hold_q <= '0;
    end else if (issue_valid_o && ready_i) begin
      issue_valid_o <= 1'b0;
      taken_o <= 1'b1;
    end else if (req_i) begin
      hold_q <= fix_d;
      issue_valid_o <= 1'b1;
    end
  end

  // Idle bus must not resemble the last instruction
  assign issue_o = issue_valid_o ? hold_q : ~hold_q;
endmodule

// [bench/test_simd_region_operand_addressing.sv]
// Purpose: self-checking bench for region operand addressing
// Assumes: decode model offers one instruction at a time
// Notes: driver queues expected channels, monitor pops them
`timescale 1ns/1ps
module test_simd_region_operand_addressing;
  typedef struct packed {
    sradr_pkg::sradr_chan_t c;
    logic d;
  } sradr_tb_exp_t;
  logic clk_sys_i = 1'b0;
  logic srst_i, req, ready_o, issue_valid, taken, chan_valid_o, done_o, err_o, rd_q;
  logic reg_wr_i, reg_rd_i;
  logic [3:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  sradr_pkg::sradr_instr_t instr, issue, ti;
  sradr_pkg::sradr_chan_t chan_o;
  sradr_pkg::sradr_opnd_t o0, o1, od;
  sradr_tb_exp_t exp_q[$];
  sradr_tb_exp_t x;
  logic [31:0] rexp_q[$], rmsk_q[$];
  int takes = 0, sent = 0;
  int fails = 0, samples_checked = 0, errs_due = 0, count_due = 0, cyc = 0, cl;

  sradr_core sradr_core_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .issue_valid_i(issue_valid), .issue_i(issue), .ready_o(ready_o),
    .chan_valid_o(chan_valid_o), .chan_o(chan_o), .done_o(done_o), .err_o(err_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  sradr_decode_model sradr_decode_model_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .req_i(req), .instr_i(instr), .ready_i(ready_o), .issue_valid_o(issue_valid),
    .issue_o(issue), .taken_o(taken));

  // Clock and cycle ceiling; a hang counts as a mismatch
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  // ****************************************
  // Reference address arithmetic
  // ****************************************
  function automatic int esz(sradr_pkg::sradr_type_t t);
    case (t)
      sradr_pkg::TY_UB, sradr_pkg::TY_B: return 1;
      sradr_pkg::TY_UW, sradr_pkg::TY_W, sradr_pkg::TY_V, sradr_pkg::TY_UV: return 2;
      default: return 4;
    endcase
  endfunction
  // Register in 32-byte units, offset in elements
  function automatic int base(sradr_pkg::sradr_opnd_t o);
    return int'(o.register_index) * 32 + int'(o.subregister_offset) * esz(o.ty);
  endfunction
  // Row-major walk: column steps, then row steps
  function automatic logic [11:0] saddr(sradr_pkg::sradr_opnd_t o, int n);
    int e = esz(o.ty);
    int w = 1 << o.width_log;
    return 12'(base(o) + (n / w) * int'(o.vertical_step) * e
      + (n % w) * int'(o.horizontal_step) * e);
  endfunction
  function automatic logic [31:0] ielem(logic [31:0] m, sradr_pkg::sradr_type_t t, int n);
    logic [3:0] nb = m[(n % 8) * 4 +: 4];
    logic [7:0] by = m[(n % 4) * 8 +: 8];
    case (t)
      sradr_pkg::TY_V: return {{28{nb[3]}}, nb};
      sradr_pkg::TY_UV: return {28'h0, nb};
      sradr_pkg::TY_VF: return {24'h0, by};
      sradr_pkg::TY_W: return {{16{m[15]}}, m[15:0]};
      sradr_pkg::TY_UW: return {16'h0, m[15:0]};
      default: return m;
    endcase
  endfunction
  function automatic sradr_pkg::sradr_opnd_t op(int ri, int so, int vs, int wl, int hs,
      sradr_pkg::sradr_type_t t);
    return '{7'(ri), 5'(so), 6'(vs), 3'(wl), 3'(hs), t};
  endfunction

  // ****************************************
  // Driver and checking tasks
  // ****************************************
  task automatic check(logic [127:0] seen, logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic plan(sradr_pkg::sradr_instr_t i, bit bad);
    int nch = 1 << i.channel_count_log;
    sradr_tb_exp_t e;
    if (bad) errs_due++;
    else begin
      count_due++;
      for (int n = 0; n < nch; n++) begin
        e.c.idx = 5'(n);
        e.c.src0_addr = saddr(i.src0, n);
        e.c.src1_addr = i.src1_imm ? 12'h000 : saddr(i.src1, n);
        e.c.dst_addr = 12'(base(i.dst) + (i.reduce ? n / 2 : n)
          * int'(i.dst.horizontal_step) * esz(i.dst.ty));
        e.c.dst_we = !(i.reduce && (n % 2 == 1));
        e.c.imm_elem = i.src1_imm ? ielem(i.imm, i.src1.ty, n) : 32'h0;
        e.d = (n == nch - 1);
        exp_q.push_back(e);
      end
    end
  endtask
  task automatic send(sradr_pkg::sradr_instr_t i);
    sent++;
    instr <= i;
    req <= 1'b1;
    @(posedge clk_sys_i);
    req <= 1'b0;
  endtask
  task automatic idle();
    int t;
    for (t = 0; t < 300 && (exp_q.size() > 0 || errs_due > 0 || issue_valid); t++)
      @(posedge clk_sys_i);
    if (t == 300) check(128'h1, 128'h0);
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic go(int c, bit red, bit im, int imm, bit bad);
    ti = '{3'(c), red, im, o0, o1, od, 32'(imm)};
    plan(ti, bad);
    send(ti);
    idle();
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e, logic [31:0] m);
    rexp_q.push_back(e & m);
    rmsk_q.push_back(m);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Monitor: channel beats, rejects and read data against notes
  always @(posedge clk_sys_i) begin
    rd_q <= reg_rd_i;
    // Every offer must be taken exactly once, accepted or rejected
    if (taken) takes++;
    if (!srst_i && chan_valid_o) begin
      x = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      check(chan_o, x.c);
      check(done_o, x.d);
    end
    if (!srst_i && err_o) begin
      check(errs_due > 0, 1'b1);
      if (errs_due > 0) errs_due--;
    end
    if (rd_q) check(reg_rdata_o & rmsk_q.pop_front(), rexp_q.pop_front());
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    srst_i = 1'b1;
    req = 1'b0;
    instr = '0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    void'($urandom(32'h0fbc));
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rd(sradr_pkg::OFF_CTRL, sradr_pkg::CTRL_RST, 32'hffffffff);
    rd(4'hc, 32'h0, 32'hffffffff);
    rd(sradr_pkg::OFF_CNT, 32'h0, 32'hffffffff);
    $display("test registers done");
    // Strided rows; dst width and vertical step are junk to be ignored
    o0 = op(4, 1, 16, 3, 2, sradr_pkg::TY_W);
    o1 = op(2, 0, 8, 3, 1, sradr_pkg::TY_W);
    od = op(6, 0, 5, 2, 1, sradr_pkg::TY_W);
    go(4, 0, 0, 0, 0);
    o0 = op(5, 0, 1, 3, 2, sradr_pkg::TY_W);
    go(4, 0, 0, 0, 0);
    // Byte sources, second one crossing into the next register
    o0 = op(1, 7, 16, 3, 1, sradr_pkg::TY_B);
    o1 = op(2, 17, 16, 3, 1, sradr_pkg::TY_UB);
    go(4, 0, 0, 0, 0);
    rd(sradr_pkg::OFF_STAT, 32'h2, 32'h3);
    // Doubleword source with reduction destination
    o0 = op(9, 3, 2, 1, 1, sradr_pkg::TY_D);
    od = op(10, 0, 0, 0, 1, sradr_pkg::TY_D);
    go(3, 1, 0, 0, 0);
    // Immediates: packed vectors and scalars
    o0 = op(3, 0, 8, 3, 1, sradr_pkg::TY_W);
    od = op(8, 0, 0, 0, 1, sradr_pkg::TY_W);
    for (int t = 7; t <= 8; t++) begin
      o1 = op(0, 0, 0, 0, 0, sradr_pkg::sradr_type_t'(t));
      go(3, 0, 1, $urandom(), 0);
    end
    for (int t = 0; t <= 3; t++) begin
      o1 = op(0, 0, 0, 0, 0, sradr_pkg::sradr_type_t'(t));
      go(3, 0, 1, $urandom(), 0);
    end
    o0 = op(3, 0, 4, 2, 1, sradr_pkg::TY_F);
    o1 = op(0, 0, 0, 0, 0, sradr_pkg::TY_VF);
    od = op(9, 4, 0, 0, 1, sradr_pkg::TY_F);
    go(2, 0, 1, $urandom(), 0);
    $display("test directed regions done");
    // Random legal regions, equal counts, destination kept in one register
    for (int r = 0; r < 16; r++) begin
      cl = $urandom_range(3, 0);
      o0 = op($urandom_range(110, 0), $urandom_range(7, 0), $urandom_range(15, 0),
        $urandom_range(cl, 0), $urandom_range(3, 0), sradr_pkg::sradr_type_t'($urandom_range(6, 0)));
      o1 = op($urandom_range(110, 0), $urandom_range(7, 0), $urandom_range(15, 0),
        $urandom_range(cl, 0), $urandom_range(3, 0), sradr_pkg::sradr_type_t'($urandom_range(6, 0)));
      od = op($urandom_range(120, 0), 0, 0, 0, 1, sradr_pkg::TY_UD);
      go(cl, 0, 0, 0, 0);
    end
    $display("test random regions done");
    // Rejects, each with its status flag
    o0 = op(3, 0, 8, 3, 1, sradr_pkg::TY_W);
    o1 = op(0, 0, 0, 0, 0, sradr_pkg::TY_UB);
    od = op(8, 0, 0, 0, 1, sradr_pkg::TY_W);
    go(3, 0, 1, 32'h12, 1);
    rd(sradr_pkg::OFF_STAT, 32'h10, 32'hf0);
    o1 = op(0, 0, 0, 0, 0, sradr_pkg::TY_V);
    od = op(8, 1, 0, 0, 1, sradr_pkg::TY_W);
    go(3, 0, 1, 32'h12, 1);
    rd(sradr_pkg::OFF_STAT, 32'h20, 32'hf0);
    o0 = op(3, 0, 8, 4, 1, sradr_pkg::TY_W);
    o1 = op(4, 0, 8, 3, 1, sradr_pkg::TY_W);
    od = op(8, 0, 0, 0, 1, sradr_pkg::TY_W);
    go(3, 0, 0, 0, 1);
    rd(sradr_pkg::OFF_STAT, 32'h40, 32'hf0);
    o0 = op(3, 0, 8, 3, 1, sradr_pkg::TY_W);
    od = op(8, 0, 0, 0, 2, sradr_pkg::TY_D);
    go(3, 0, 0, 0, 1);
    rd(sradr_pkg::OFF_STAT, 32'h80, 32'hf0);
    $display("test rejects done");
    // Disabled core must leave the offer waiting
    wr(sradr_pkg::OFF_CTRL, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    od = op(8, 0, 0, 0, 1, sradr_pkg::TY_W);
    ti = '{3'd3, 1'b0, 1'b0, o0, o1, od, 32'h0};
    plan(ti, 0);
    send(ti);
    repeat (4) @(posedge clk_sys_i);
    check(ready_o, 1'b0);
    check(issue_valid, 1'b1);
    wr(sradr_pkg::OFF_CTRL, 32'h1);
    idle();
    rd(sradr_pkg::OFF_CNT, 32'(count_due), 32'hffff);
    wr(sradr_pkg::OFF_CNT, 32'h0);
    rd(sradr_pkg::OFF_CNT, 32'h0, 32'hffff);
    $display("test control and count done");
    check(exp_q.size(), 0);
    check(takes, sent);
    summarize();
  end
endmodule
